// ==== rtl/sdf_filter_ctl.sv ====
// Summary of operation
// - A write that changes the control register resets both converters.
// - Control register is 16-bit read/write, reset value 0x0007.
// - Bit 15 applies system chopping to all active converters.
// - Chop with zero averaging factor divides rate by 3, else no change.
// - With chopping, a result settles after two output periods.
// - Bit 14 enables running average of two; chopping forces it on.
// - Running average alone keeps rate, adds one settling period.
// - Bits 13:8 hold the 6-bit post-filter averaging factor.
// - Bit 7 adds a second notch at 1.333 times the first.
// - Bits 6:0 set decimation; rate is 512000/((factor+1)*64) Hz.
// - Decimation 126 forces 60 Hz, decimation 127 forces 50 Hz.
// - Low-power mode clocks the filter at 131072 Hz instead.
// - Nonzero averaging factor divides the rate further by 3+factor.
// - Settling without chop: 3, 4 with average, 1 with factor, 2 both.
// - First result waits an extra 60 us per converter.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none

module sdf_filter_ctl
    import sdf_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [15:0] rd_data_out,
    input wire logic low_power_in,
    output logic pri_conv_reset_out,
    output logic aux_conv_reset_out,
    output logic chop_on_out,
    output logic chop_phase_out,
    output logic running_avg_two_on_out,
    output logic [5:0] post_avg_factor_out,
    output logic second_notch_on_out,
    output logic [6:0] decim_factor_out,
    output logic mod_tick_out,
    output logic pri_result_valid_out,
    output logic aux_result_valid_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    sdf_link_if link ();

    logic [15:0] filter_ctl_reg_q, filter_ctl_reg_d;
    logic [15:0] rd_data_q, rd_data_d;
    logic restart_q, restart_d;
    logic lp_q, lp_d;
    logic phase_q, phase_d;
    logic combo_bad_q, combo_bad_d;
    logic [SDF_PERIOD_W-1:0] period_q, period_d;
    logic [2:0] need_q, need_d;
    logic ravg_out_q, ravg_out_d;

    logic system_chop_on;
    logic running_avg_two_on;
    logic [5:0] post_avg_factor;
    logic second_notch_on;
    logic [6:0] decim_factor;
    logic af_nonzero;
    logic ctl_hit;
    logic stat_hit;
    logic ctl_change;
    logic [SDF_BASE_W-1:0] base_len;
    logic [SDF_MULT_W-1:0] mult;
    logic [15:0] status;
    logic pri_settled;
    logic aux_settled;
    logic pri_valid;
    logic aux_valid;

    ////////////////////////////////////////////////////////////////////////
    // Field decode

    assign system_chop_on = filter_ctl_reg_q[SDF_CHOP_BIT];
    assign running_avg_two_on = filter_ctl_reg_q[SDF_RAVG_BIT];
    assign post_avg_factor =
        filter_ctl_reg_q[SDF_AF_LSB +: SDF_AF_W];
    assign second_notch_on = filter_ctl_reg_q[SDF_NOTCH_BIT];
    assign decim_factor = filter_ctl_reg_q[SDF_SF_LSB +: SDF_SF_W];
    assign af_nonzero = (post_avg_factor != '0);

    assign ctl_hit = (addr_in == SDF_CTL_ADDR);
    assign stat_hit = (addr_in == SDF_STAT_ADDR);
    assign ctl_change = wr_en_in && ctl_hit &&
        (wr_data_in != filter_ctl_reg_q);

    ////////////////////////////////////////////////////////////////////////
    // Control register

    always_comb begin
        filter_ctl_reg_d = filter_ctl_reg_q;
        if (wr_en_in && ctl_hit) begin
            filter_ctl_reg_d = wr_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            filter_ctl_reg_q <= SDF_CTL_RESET;
        end else begin
            filter_ctl_reg_q <= filter_ctl_reg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source sample

    always_comb begin
        lp_d = low_power_in;
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lp_q <= 1'b0;
        end else begin
            lp_q <= lp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter restart

    always_comb begin
        // A write that changes the value, or a clock source change, restarts both channels
        restart_d = ctl_change || (lp_q != low_power_in);
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= restart_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output period in modulator ticks

    always_comb begin
        // Sinc stage length
        if (decim_factor == SDF_SF_FORCE_60) begin
            base_len = lp_q ?
                SDF_BASE_W'(SDF_MOD_HZ_LOW / SDF_HZ_60) :
                SDF_BASE_W'(SDF_MOD_HZ_NORMAL / SDF_HZ_60);
        end else if (decim_factor == SDF_SF_FORCE_50) begin
            base_len = lp_q ?
                SDF_BASE_W'(SDF_MOD_HZ_LOW / SDF_HZ_50) :
                SDF_BASE_W'(SDF_MOD_HZ_NORMAL / SDF_HZ_50);
        end else begin
            base_len = (SDF_BASE_W'(decim_factor) + SDF_BASE_W'(1))
                << SDF_SINC_SHIFT;
        end
        // Post-filter and chop multiplier
        if (af_nonzero) begin
            mult = SDF_MULT_W'(post_avg_factor) + SDF_AF_OFFSET;
        end else if (system_chop_on) begin
            mult = SDF_CHOP_DIV;
        end else begin
            mult = SDF_MULT_W'(1);
        end
        period_d = SDF_PERIOD_W'(base_len) * SDF_PERIOD_W'(mult);
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            period_q <= '0;
        end else begin
            period_q <= period_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settling length

    always_comb begin
        if (system_chop_on) begin
            need_d = SDF_SETTLE_CHOP;
        end else begin
            unique case ({af_nonzero, running_avg_two_on})
                2'b00: need_d = SDF_SETTLE_PLAIN;
                2'b01: need_d = SDF_SETTLE_RAVG;
                2'b10: need_d = SDF_SETTLE_AF;
                2'b11: need_d = SDF_SETTLE_AF_RAVG;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            need_q <= SDF_SETTLE_PLAIN;
        end else begin
            need_q <= need_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Combination check

    always_comb begin
        // Flags combinations the data path cannot carry
        combo_bad_d =
            ((decim_factor >= SDF_SF_LIM_MID) &&
             (decim_factor < SDF_SF_LIM_HIGH) &&
             (post_avg_factor > SDF_AF_LIM_MID)) ||
            ((decim_factor >= SDF_SF_LIM_HIGH) && af_nonzero);
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            combo_bad_q <= 1'b0;
        end else begin
            combo_bad_q <= combo_bad_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chop phase

    always_comb begin
        phase_d = phase_q;
        if (restart_q || !system_chop_on) begin
            phase_d = 1'b0;
        end else if (link.out_tick) begin
            phase_d = ~phase_q;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate generator and channel settling

    assign link.low_power = lp_q;
    assign link.period_len = period_q;
    assign link.restart = restart_q;
    assign link.settle_need = need_q;

    sdf_tick_gen u_tick (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .link(link.gen)
    );

    sdf_settle #(
        .START_CYC(SDF_START_W'(SDF_START_CYC))
    ) u_pri (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .link(link.chan),
        .valid_out(pri_valid),
        .settled_out(pri_settled)
    );

    sdf_settle #(
        .START_CYC(SDF_START_W'(2 * SDF_START_CYC))
    ) u_aux (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .link(link.chan),
        .valid_out(aux_valid),
        .settled_out(aux_settled)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status word

    always_comb begin
        status = '0;
        status[SDF_ST_PRI_SETTLED] = pri_settled;
        status[SDF_ST_AUX_SETTLED] = aux_settled;
        status[SDF_ST_LOW_POWER] = lp_q;
        status[SDF_ST_COMBO_BAD] = combo_bad_q;
        status[SDF_ST_CHOP_PHASE] = phase_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port

    always_comb begin
        rd_data_d = '0;
        if (rd_en_in && ctl_hit) begin
            rd_data_d = filter_ctl_reg_q;
        end else if (rd_en_in && stat_hit) begin
            rd_data_d = status;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered running average enable

    always_comb begin
        ravg_out_d = filter_ctl_reg_d[SDF_RAVG_BIT] |
            filter_ctl_reg_d[SDF_CHOP_BIT];
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ravg_out_q <= SDF_CTL_RESET[SDF_RAVG_BIT] |
                SDF_CTL_RESET[SDF_CHOP_BIT];
        end else begin
            ravg_out_q <= ravg_out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data_out = rd_data_q;
    assign pri_conv_reset_out = restart_q;
    assign aux_conv_reset_out = restart_q;
    assign chop_on_out = system_chop_on;
    assign chop_phase_out = phase_q;
    assign running_avg_two_on_out = ravg_out_q;
    assign post_avg_factor_out = post_avg_factor;
    assign second_notch_on_out = second_notch_on;
    assign decim_factor_out = decim_factor;
    assign mod_tick_out = link.mod_tick;
    assign pri_result_valid_out = pri_valid;
    assign aux_result_valid_out = aux_valid;

endmodule

`default_nettype wire

// ==== rtl/sdf_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface sdf_link_if;
    import sdf_pkg::*;
    logic low_power;
    logic [SDF_PERIOD_W-1:0] period_len;
    logic restart;
    logic [2:0] settle_need;
    logic mod_tick;
    logic out_tick;

    modport ctl (
        output low_power, period_len, restart, settle_need,
        input mod_tick, out_tick
    );
    modport gen (
        input low_power, period_len, restart,
        output mod_tick, out_tick
    );
    modport chan (
        input restart, settle_need, out_tick
    );
endinterface

`default_nettype wire

// ==== rtl/sdf_pkg.sv ====
package sdf_pkg;

    // Register map
    localparam logic [31:0] SDF_CTL_ADDR = 32'hffff_0514;
    localparam logic [31:0] SDF_STAT_ADDR = 32'hffff_0510;
    localparam logic [15:0] SDF_CTL_RESET = 16'h0007;

    // Control field layout
    localparam int SDF_CHOP_BIT = 15;
    localparam int SDF_RAVG_BIT = 14;
    localparam int SDF_AF_LSB = 8;
    localparam int SDF_AF_W = 6;
    localparam int SDF_NOTCH_BIT = 7;
    localparam int SDF_SF_LSB = 0;
    localparam int SDF_SF_W = 7;

    // Status field layout
    localparam int SDF_ST_PRI_SETTLED = 0;
    localparam int SDF_ST_AUX_SETTLED = 1;
    localparam int SDF_ST_LOW_POWER = 2;
    localparam int SDF_ST_COMBO_BAD = 3;
    localparam int SDF_ST_CHOP_PHASE = 4;

    // Clocks
    localparam int SDF_MCLK_HZ = 25_000_000;
    localparam int SDF_MOD_HZ_NORMAL = 512_000;
    localparam int SDF_MOD_HZ_LOW = 131_072;
    localparam int SDF_ACC_W = 25;

    // Rate arithmetic
    localparam int SDF_SINC_SHIFT = 6;
    localparam int SDF_BASE_W = 14;
    localparam int SDF_MULT_W = 7;
    localparam int SDF_PERIOD_W = 21;
    localparam logic [6:0] SDF_SF_FORCE_60 = 7'h7e;
    localparam logic [6:0] SDF_SF_FORCE_50 = 7'h7f;
    localparam logic [6:0] SDF_SF_MAX_STD = 7'h7d;
    localparam int SDF_HZ_60 = 60;
    localparam int SDF_HZ_50 = 50;
    localparam logic [6:0] SDF_CHOP_DIV = 7'h03;
    localparam logic [6:0] SDF_AF_OFFSET = 7'h03;
    localparam logic [6:0] SDF_SF_LIM_MID = 7'h20;
    localparam logic [6:0] SDF_SF_LIM_HIGH = 7'h40;
    localparam logic [5:0] SDF_AF_LIM_MID = 6'h07;

    // Settling in output periods
    localparam logic [2:0] SDF_SETTLE_CHOP = 3'h2;
    localparam logic [2:0] SDF_SETTLE_PLAIN = 3'h3;
    localparam logic [2:0] SDF_SETTLE_RAVG = 3'h4;
    localparam logic [2:0] SDF_SETTLE_AF = 3'h1;
    localparam logic [2:0] SDF_SETTLE_AF_RAVG = 3'h2;

    // First-result delay per converter
    localparam int SDF_MCLK_PERIOD_NS = 40;
    localparam int SDF_START_NS = 60_000;
    localparam int SDF_START_CYC =
        (SDF_START_NS + SDF_MCLK_PERIOD_NS - 1) / SDF_MCLK_PERIOD_NS;
    localparam int SDF_START_W = 13;

    typedef enum logic [1:0] {
        SDF_ST_WAIT = 2'b00,
        SDF_ST_SETTLE = 2'b01,
        SDF_ST_RUN = 2'b10
    } sdf_chan_state_t;

endpackage

// ==== rtl/sdf_settle.sv ====
`timescale 1ns/100ps
`default_nettype none

module sdf_settle
    import sdf_pkg::*;
#(
    parameter logic [SDF_START_W-1:0] START_CYC = SDF_START_W'(SDF_START_CYC)
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    sdf_link_if.chan link,
    output logic valid_out,
    output logic settled_out
);
    sdf_chan_state_t st_q, st_d;
    logic [SDF_START_W-1:0] wait_q, wait_d;
    logic [2:0] per_q, per_d;
    logic valid_q, valid_d;

    always_comb begin
        st_d = st_q;
        wait_d = wait_q;
        per_d = per_q;
        valid_d = 1'b0;
        unique case (st_q)
            SDF_ST_WAIT: begin
                // First-result delay
                if (wait_q >= START_CYC - SDF_START_W'(1)) begin
                    st_d = SDF_ST_SETTLE;
                    per_d = '0;
                end else begin
                    wait_d = wait_q + SDF_START_W'(1);
                end
            end
            SDF_ST_SETTLE: begin
                if (link.out_tick) begin
                    per_d = per_q + 3'h1;
                    if (per_q + 3'h1 >= link.settle_need) begin
                        st_d = SDF_ST_RUN;
                        valid_d = 1'b1;
                    end
                end
            end
            SDF_ST_RUN: begin
                valid_d = link.out_tick;
            end
            default: begin
                st_d = SDF_ST_WAIT;
            end
        endcase
        if (link.restart) begin
            st_d = SDF_ST_WAIT;
            wait_d = '0;
            per_d = '0;
            valid_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= SDF_ST_WAIT;
            wait_q <= '0;
            per_q <= '0;
            valid_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wait_q <= wait_d;
            per_q <= per_d;
            valid_q <= valid_d;
        end
    end

    assign valid_out = valid_q;
    assign settled_out = (st_q == SDF_ST_RUN);
endmodule

`default_nettype wire

// ==== rtl/sdf_tick_gen.sv ====
`timescale 1ns/100ps
`default_nettype none

module sdf_tick_gen
    import sdf_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    sdf_link_if.gen link
);
    logic [SDF_ACC_W-1:0] acc_q, acc_d;
    logic [SDF_PERIOD_W-1:0] cnt_q, cnt_d;
    logic mod_q, mod_d;
    logic out_q, out_d;
    logic [SDF_ACC_W:0] sum;

    // Fractional divider for the modulator clock
    always_comb begin
        sum = {1'b0, acc_q} + (link.low_power ?
            (SDF_ACC_W+1)'(SDF_MOD_HZ_LOW) :
            (SDF_ACC_W+1)'(SDF_MOD_HZ_NORMAL));
        mod_d = 1'b0;
        acc_d = sum[SDF_ACC_W-1:0];
        if (sum >= (SDF_ACC_W+1)'(SDF_MCLK_HZ)) begin
            mod_d = 1'b1;
            acc_d = SDF_ACC_W'(sum - (SDF_ACC_W+1)'(SDF_MCLK_HZ));
        end
        out_d = 1'b0;
        cnt_d = cnt_q;
        if (link.restart) begin
            cnt_d = '0;
        end else if (mod_q) begin
            if (cnt_q >= link.period_len - SDF_PERIOD_W'(1)) begin
                cnt_d = '0;
                out_d = 1'b1;
            end else begin
                cnt_d = cnt_q + SDF_PERIOD_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_q <= '0;
            cnt_q <= '0;
            mod_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            mod_q <= mod_d;
            out_q <= out_d;
        end
    end

    assign link.mod_tick = mod_q;
    assign link.out_tick = out_q;
endmodule

`default_nettype wire

// ==== test/sdf_filter_ctl_props.sv ====
`timescale 1ns/100ps
`default_nettype none

module sdf_ctl_props
    import sdf_pkg::*;
(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [31:0] addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [15:0] rd_data_out,
    input wire logic pri_conv_reset_out,
    input wire logic aux_conv_reset_out,
    input wire logic chop_on_out,
    input wire logic chop_phase_out,
    input wire logic running_avg_two_on_out,
    input wire logic [5:0] post_avg_factor_out,
    input wire logic second_notch_on_out,
    input wire logic [6:0] decim_factor_out,
    input wire logic pri_result_valid_out,
    input wire logic aux_result_valid_out
);
    logic [15:0] shadow_q;
    logic [15:0] shadow_d;
    logic [11:0] since_q;
    logic [11:0] since_d;
    logic ctl_wr;

    assign ctl_wr = wr_en_in && addr_in == SDF_CTL_ADDR;

    always_comb begin
        shadow_d = ctl_wr ? wr_data_in : shadow_q;
        since_d = since_q;
        if (pri_conv_reset_out) begin
            since_d = 12'h000;
        end else if (since_q != 12'hfff) begin
            since_d = since_q + 12'h001;
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            shadow_q <= SDF_CTL_RESET;
            since_q <= 12'h000;
        end else begin
            shadow_q <= shadow_d;
            since_q <= since_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_RST_PAIR: assert property (
        pri_conv_reset_out == aux_conv_reset_out) else $error("reset split");
    AST_RST_WRITE: assert property (
        ctl_wr && wr_data_in != shadow_q |=> pri_conv_reset_out)
        else $error("no converter reset on change");
    AST_RD_CTL: assert property (
        rd_en_in && addr_in == SDF_CTL_ADDR |=> rd_data_out == shadow_q)
        else $error("control read wrong");
    AST_RD_IDLE: assert property (
        !$past(rd_en_in) |-> rd_data_out == 16'h0000)
        else $error("read data outside read slot");
    AST_CHOP: assert property (
        chop_on_out == shadow_q[15]) else $error("chop level wrong");
    AST_RAVG: assert property (
        running_avg_two_on_out == (shadow_q[14] | shadow_q[15]))
        else $error("running average wrong");
    AST_FIELDS: assert property (
        {post_avg_factor_out, second_notch_on_out, decim_factor_out}
        == shadow_q[13:0]) else $error("field outputs wrong");
    AST_PHASE_OFF: assert property (
        !chop_on_out && !$past(chop_on_out) |-> !chop_phase_out)
        else $error("chop phase without chop");
    AST_PRI_DELAY: assert property (
        pri_result_valid_out |-> since_q >= 12'h5d2)
        else $error("primary result too early");
    AST_AUX_DELAY: assert property (
        aux_result_valid_out |-> since_q >= 12'hbae)
        else $error("aux result too early");
    AST_VALID_ONE: assert property (
        pri_result_valid_out |=> !pri_result_valid_out)
        else $error("valid longer than one cycle");
endmodule

bind sdf_filter_ctl sdf_ctl_props sdf_ctl_props_inst (
    .mclk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
    .rd_data_out, .pri_conv_reset_out, .aux_conv_reset_out, .chop_on_out,
    .chop_phase_out, .running_avg_two_on_out, .post_avg_factor_out,
    .second_notch_on_out, .decim_factor_out, .pri_result_valid_out,
    .aux_result_valid_out
);

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import sdf_pkg::*;
;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [31:0] addr_in = 32'h0000_0000;
    logic [15:0] wr_data_in = 16'h0000;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic low_power_in = 1'b0;
    logic [15:0] rd_data_out;
    logic pri_conv_reset_out;
    logic aux_conv_reset_out;
    logic chop_on_out;
    logic chop_phase_out;
    logic running_avg_two_on_out;
    logic [5:0] post_avg_factor_out;
    logic second_notch_on_out;
    logic [6:0] decim_factor_out;
    logic mod_tick_out;
    logic pri_result_valid_out;
    logic aux_result_valid_out;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;

    always #20 mclk_in = ~mclk_in;

    sdf_filter_ctl sdf_filter_ctl_inst (
        .mclk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in, .rd_en_in,
        .rd_data_out, .low_power_in, .pri_conv_reset_out, .aux_conv_reset_out,
        .chop_on_out, .chop_phase_out, .running_avg_two_on_out,
        .post_avg_factor_out, .second_notch_on_out, .decim_factor_out,
        .mod_tick_out, .pri_result_valid_out, .aux_result_valid_out
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask

    task automatic count_ticks(output int n);
        n = 0;
        repeat (3125) begin
            @(posedge mclk_in);
            #1;
            n += mod_tick_out;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [15:0] d;
        rd(SDF_CTL_ADDR, d);
        chk("ctl reset", d, 16'h0007);
        wr(SDF_CTL_ADDR, 16'h2b95);
        rd(SDF_CTL_ADDR, d);
        chk("ctl readback", d, 16'h2b95);
        chk("avg factor", post_avg_factor_out, 6'h2b);
        chk("notch", second_notch_on_out, 1'b1);
        chk("decim", decim_factor_out, 7'h15);
        wr(SDF_STAT_ADDR, 16'hffff);
        wr(32'hffff_0500, 16'h1234);
        rd(32'hffff_0500, d);
        chk("unmapped read", d, 16'h0000);
        rd(SDF_CTL_ADDR, d);
        chk("ctl kept", d, 16'h2b95);
    endtask

    task automatic t_conv();
        wr(SDF_CTL_ADDR, 16'h0007);
        #1;
        chk("pri reset", pri_conv_reset_out, 1'b1);
        chk("aux reset", aux_conv_reset_out, 1'b1);
        @(posedge mclk_in);
        #1;
        chk("reset width", pri_conv_reset_out, 1'b0);
        wr(SDF_CTL_ADDR, 16'h0007);
        #1;
        chk("same value", pri_conv_reset_out, 1'b0);
    endtask

    task automatic t_chop();
        wr(SDF_CTL_ADDR, 16'h8007);
        #1;
        chk("chop on", chop_on_out, 1'b1);
        chk("avg forced", running_avg_two_on_out, 1'b1);
        wr(SDF_CTL_ADDR, 16'h4007);
        #1;
        chk("chop off", chop_on_out, 1'b0);
        chk("avg bit", running_avg_two_on_out, 1'b1);
        wr(SDF_CTL_ADDR, 16'h0007);
        #1;
        chk("avg off", running_avg_two_on_out, 1'b0);
    endtask

    task automatic t_lp();
        int n;
        logic [15:0] d;
        count_ticks(n);
        chk("ticks normal", n, 64);
        @(posedge mclk_in);
        low_power_in <= 1'b1;
        count_ticks(n);
        chk("ticks low", n == 16 || n == 17, 1'b1);
        rd(SDF_STAT_ADDR, d);
        chk("status low power", d, 16'h0004);
        @(posedge mclk_in);
        low_power_in <= 1'b0;
    endtask

    task automatic t_rate(input logic [15:0] v, input int p, input int n);
        int t;
        int p1 = 0;
        int p2 = 0;
        int a1 = 0;
        wr(SDF_CTL_ADDR, v);
        for (t = 0; t < 1600 + (n + 1) * p && p2 == 0; t++) begin
            @(posedge mclk_in);
            #1;
            if (pri_result_valid_out === 1'b1) begin
                if (p1 == 0) begin
                    p1 = t;
                end else begin
                    p2 = t;
                end
            end
            if (aux_result_valid_out === 1'b1 && a1 == 0) begin
                a1 = t;
            end
        end
        chk("first", p1 > 1497 + (n - 1) * p && p1 <= 1503 + n * p, 1);
        chk("aux", a1 > 2997 + (n - 1) * p && a1 <= 3003 + n * p, 1);
        chk("period", p2 - p1, p);
        chk("chop phase", chop_phase_out, v[15]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_conv();
        t_chop();
        t_lp();
        t_rate(16'h0000, 3125, 3);
        t_rate(16'h4000, 3125, 4);
        t_rate(16'h8000, 9375, 2);
        t_rate(16'h0100, 12500, 1);
        close_out();
    end
endmodule

`default_nettype wire
